// file: core/tfx_defines.vh
// Purpose: constants for the tape formatter task executor
// Assumes: 200 MHz controller clock
// Notes: task codes of this block's own command port
`ifndef TFX_DEFINES_VH
`define TFX_DEFINES_VH
`define TFX_CMD_NOP 16'h0000
`define TFX_CMD_SENSE 16'h009c
`define TFX_CMD_CLEAR 16'h009d
`define TFX_CMD_WTM 16'h0001
`define TFX_CMD_WRITE 16'h0002
`define TFX_CMD_SDS 16'h0003
`define TFX_CMD_LOOP 16'h0004
`define TFX_OP_MASK 16'hff00
`define TFX_REG_SENSE_LO 8'h1c
`define TFX_REG_SENSE_HI 8'h1e
`define TFX_REG_DETAIL3 8'h36
`define TFX_CFG_FMT_BIT 7
`define TFX_ST1_OPCHK 11
`define TFX_ST2_DCHK 15
`define TFX_RETRY_FIRST 4'h5
`define TFX_RETRY_LATER 4'ha
`define TFX_RAMP_NS 100000
`define TFX_CLK_NS 5
`define TFX_FIFO_DEPTH 4
`define TFX_FIFO_AW 2
`define TFX_MODE_PE 2'h2
`define TFX_MODE_GCR 2'h3
`endif

// file: core/tfx_fifo.v
// Purpose: small data buffer between adapter and tape write path
// Assumes: single clock, same-cycle push and pop allowed
// Notes: width and depth shape the storage
`timescale 1ns/1ps
`default_nettype none
module tfx_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out,
    // level
    output wire [AW:0] count_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;
    assign in_ready_out = (cnt_q != DEPTH[AW:0]);
    assign out_valid_out = |cnt_q;
    assign out_data_out = mem_q[rp_q];
    assign count_out = cnt_q;
    always @(posedge sys_clk_in) begin
        if (push) begin
            mem_q[wp_q] <= in_data_in;
        end
    end
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: core/tfx_task_executor.v
// Purpose: task execution of a tape formatter behind an adapter channel
// Assumes: transport pins asynchronous; adapter logic on sys_clk_in
// Notes: one block written per data word burst; detail words by index
// Operation
// [R1] write tape mark moves forward, erases, writes mode mark, no data
// [R2] read-back verifies erase and mark; stop in gap after mark
// [R3] unbuffered: busy held until mark is on tape
// [R4] buffered: mark queued, busy drops; second consecutive mark holds busy
// [R5] unbuffered write records one block, format from config bit 7
// [R6] each block verified by read head; stop in following gap
// [R7] write on protected reel: no data, no motion, operation check set
// [R8] buffered write fills buffer with request pulses; stop ends busy
// [R9] tape motion starts during filling after ramp; drain at speed
// [R10] non-write command waits until buffer drains to tape; code holds task codes 1 to 7, write included, and runs sense and clear at once
// [R11] first-block data check: rewind, erase, rewrite up to five times
// [R12] later block: reverse, erase, rewrite five times, repeat to ten
// [R13] errors counted in sense byte; uncorrectable sets word two bit 15
// [R14] no-op changes nothing, nak when busy, normal termination; code clears both status words and reloads the format bit on a no-op
// [R15] detail status send starts at command bits 13-15, up to eight; code takes the start index from bits 10-8
// [R16] detail words: tracks, errors, rejects, sense, check, reserved
// [R17] sense byte: eot, bot, protect, gap inhibit, density; reverse zero
// [R18] sense byte: ready, online, write status when write and erase
// [R19] loop write-to-read: no motion, data looped to read path
// [R20] sense bytes latched at reset; byte zero copied after each task; code copies it only after mark, write, loop and sense tasks
// [R21] sense task steps byte pointer; device clear resets it and busy
// [R22] sense byte two: mode 10 pe, 11 gcr, speed code three bits
`timescale 1ns/1ps
`default_nettype none
`include "tfx_defines.vh"
module tfx_task_executor (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // adapter task port
    input wire task_valid_in,
    input wire [15:0] task_code_in,
    output wire task_nak_out,
    output reg busy_out,
    input wire buffered_mode_in,
    input wire [15:0] config_word_in,
    // adapter data port
    input wire wr_data_valid_in,
    input wire [15:0] wr_data_in,
    input wire adapter_stop_in,
    output reg transfer_request_strobe_out,
    input wire [7:0] rate_div_in,
    // register input port
    input wire [7:0] reg_addr_in,
    output reg [15:0] reg_data_out,
    output reg [15:0] status1_out,
    output reg [15:0] status2_out,
    // detail status stream
    output reg [15:0] detail_data_out,
    output reg detail_valid_out,
    input wire [3:0] detail_range_in,
    // tape transport pins
    input wire end_of_tape_flag_in,
    input wire load_point_flag_in,
    input wire reel_protect_flag_in,
    input wire rewinding_in,
    input wire online_in,
    input wire read_check_in,
    input wire up_to_speed_in,
    input wire [2:0] speed_code_in,
    output reg motion_fwd_out,
    output reg motion_rev_out,
    output reg erase_out,
    output reg write_en_out,
    output reg mark_out,
    output reg loopback_out,
    output reg [15:0] tape_data_out,
    output reg tape_data_valid_out
);
    localparam RAMP_CYC = (`TFX_RAMP_NS + `TFX_CLK_NS - 1) / `TFX_CLK_NS;
    localparam S_IDLE = 8'h01, S_RAMP = 8'h02, S_WRITE = 8'h04;
    localparam S_VERIFY = 8'h08, S_REPOS = 8'h10, S_MARK = 8'h20;
    localparam S_SDS = 8'h40, S_DRAIN = 8'h80;

    // ==================================================================
    // pin synchronisers
    reg [10:0] pin_m_q, pin_s_q;
    wire eot_s = pin_s_q[0], bot_s = pin_s_q[1], prot_s = pin_s_q[2];
    wire rew_s = pin_s_q[3], onl_s = pin_s_q[4], rchk_s = pin_s_q[5];
    wire spd_ok_s = pin_s_q[6];
    wire [2:0] spd_s = pin_s_q[9:7];
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_m_q <= 11'h000;
            pin_s_q <= 11'h000;
        end else begin
            pin_m_q <= {1'b0, speed_code_in, up_to_speed_in, read_check_in,
                online_in, rewinding_in, reel_protect_flag_in,
                load_point_flag_in, end_of_tape_flag_in};
            pin_s_q <= pin_m_q;
        end
    end

    // ==================================================================
    // sense bytes
    reg [7:0] err_cnt_q;
    reg gcr_q;
    wire [7:0] sb0_now = {eot_s, bot_s, write_en_out & ~erase_out,
        write_en_out & erase_out, prot_s, gcr_q, ~rew_s, onl_s}; // [R17] [R18]
    wire [7:0] sb2_now = {gcr_q ? `TFX_MODE_GCR : `TFX_MODE_PE,
        3'h0, spd_s}; // [R22]

    // ==================================================================
    // buffer
    wire fifo_in_ready, fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire [`TFX_FIFO_AW:0] fifo_cnt;
    reg drain_q;
    tfx_fifo #(.WIDTH(16), .DEPTH(`TFX_FIFO_DEPTH), .AW(`TFX_FIFO_AW)) u_buf (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(wr_data_valid_in),
        .in_ready_out(fifo_in_ready),
        .in_data_in(wr_data_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(drain_q),
        .out_data_out(fifo_out_data),
        .count_out(fifo_cnt)
    );

    // ==================================================================
    // control
    reg [7:0] st_q;
    reg [16:0] tmr_q;
    reg [7:0] rdiv_q;
    reg [3:0] retry_q, rounds_q;
    reg first_blk_q, filling_q, mark_pend_q, last_mark_q, loop_q;
    reg [15:0] pend_q;
    reg pend_v_q;
    reg [2:0] ds_ptr_q;
    reg [3:0] ds_left_q;
    reg [5:0] sense_ptr_q;
    reg [15:0] detail3_q, sense_lo_q, sense_hi_q, crc_q;
    reg [1:0] init_q;
    wire [15:0] op = pend_v_q ? pend_q : task_code_in; // [R10]
    assign task_nak_out = task_valid_in && busy_out &&
        task_code_in == `TFX_CMD_NOP; // [R14]
    wire take = pend_v_q ? st_q == S_IDLE : task_valid_in && !busy_out;
    wire [15:0] op_k = op & ~`TFX_OP_MASK;
    wire is_wr = op_k == `TFX_CMD_WRITE;
    wire is_loop = op_k == `TFX_CMD_LOOP;

    function [15:0] detail_word;
        input [2:0] idx;
        input [15:0] errs, s3, crc;
        begin
            case (idx) // [R16]
                3'h1: detail_word = errs;
                3'h3: detail_word = s3;
                3'h4: detail_word = crc;
                default: detail_word = 16'h0000;
            endcase
        end
    endfunction

    always @(*) begin
        case (reg_addr_in)
            `TFX_REG_SENSE_LO: reg_data_out = sense_lo_q; // [R20]
            `TFX_REG_SENSE_HI: reg_data_out = sense_hi_q;
            `TFX_REG_DETAIL3: reg_data_out = detail3_q; // [R21]
            default: reg_data_out = 16'h0000;
        endcase
    end

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= S_IDLE;
            busy_out <= 1'b0;
            tmr_q <= 17'h00000;
            rdiv_q <= 8'h00;
            retry_q <= 4'h0;
            rounds_q <= 4'h0;
            first_blk_q <= 1'b1;
            filling_q <= 1'b0;
            mark_pend_q <= 1'b0;
            last_mark_q <= 1'b0;
            loop_q <= 1'b0;
            pend_q <= 16'h0000;
            pend_v_q <= 1'b0;
            ds_ptr_q <= 3'h0;
            ds_left_q <= 4'h0;
            sense_ptr_q <= 6'h00;
            detail3_q <= 16'h0000;
            sense_lo_q <= 16'h0000;
            sense_hi_q <= 16'h0000;
            crc_q <= 16'h0000;
            err_cnt_q <= 8'h00;
            gcr_q <= 1'b0;
            init_q <= 2'h0;
            drain_q <= 1'b0;
            status1_out <= 16'h0000;
            status2_out <= 16'h0000;
            detail_data_out <= 16'h0000;
            detail_valid_out <= 1'b0;
            transfer_request_strobe_out <= 1'b0;
            motion_fwd_out <= 1'b0;
            motion_rev_out <= 1'b0;
            erase_out <= 1'b0;
            write_en_out <= 1'b0;
            mark_out <= 1'b0;
            loopback_out <= 1'b0;
            tape_data_out <= 16'h0000;
            tape_data_valid_out <= 1'b0;
        end else begin
            detail_valid_out <= 1'b0;
            transfer_request_strobe_out <= 1'b0;
            tape_data_valid_out <= 1'b0;
            drain_q <= 1'b0;
            if (init_q != 2'h3) begin
                init_q <= init_q + 2'h1;
            end
            if (init_q == 2'h2) begin
                sense_lo_q <= {sb0_now, 8'h00}; // [R20]
                sense_hi_q <= {sb2_now, 8'h00};
                detail3_q <= {sb0_now, 8'h00};
            end
            // request pulses at the adapter's rate
            if (filling_q) begin // [R8]
                rdiv_q <= rdiv_q + 8'h01;
                if (rdiv_q == rate_div_in && fifo_in_ready) begin
                    rdiv_q <= 8'h00;
                    transfer_request_strobe_out <= 1'b1;
                end
                if (adapter_stop_in) begin
                    filling_q <= 1'b0;
                    busy_out <= 1'b0; // [R8]
                end
            end
            if (take) begin
                status1_out <= 16'h0000;
                status2_out <= 16'h0000;
                busy_out <= 1'b0;
                gcr_q <= config_word_in[`TFX_CFG_FMT_BIT]; // [R5]
                if (op == `TFX_CMD_NOP) begin
                    // task reset only [R14]
                end else if (op == `TFX_CMD_CLEAR) begin
                    sense_ptr_q <= 6'h00; // [R21]
                    busy_out <= 1'b0;
                    mark_pend_q <= 1'b0;
                end else if (op == `TFX_CMD_SENSE) begin
                    sense_ptr_q <= sense_ptr_q + 6'h01; // [R21]
                    detail3_q <= (sense_ptr_q == 6'h02) ?
                        {sb2_now, 8'h00} : {sb0_now, err_cnt_q}; // [R13]
                end else if (op[15:3] == 13'h0000 && op != `TFX_CMD_NOP &&
                        st_q != S_IDLE) begin
                    pend_q <= op; // [R10]
                    pend_v_q <= 1'b1;
                    busy_out <= 1'b1;
                end else if (op_k == `TFX_CMD_SDS) begin
                    ds_ptr_q <= op[10:8]; // [R15]
                    ds_left_q <= detail_range_in;
                    st_q <= S_SDS;
                    busy_out <= 1'b1;
                end else if ((is_wr || op_k == `TFX_CMD_WTM) && prot_s) begin
                    status1_out[`TFX_ST1_OPCHK] <= 1'b1; // [R7]
                end else if (op_k == `TFX_CMD_WTM) begin
                    if (buffered_mode_in && !last_mark_q) begin
                        mark_pend_q <= 1'b1; // [R4]
                        busy_out <= 1'b0;
                    end else begin
                        busy_out <= 1'b1; // [R3] [R4]
                    end
                    last_mark_q <= 1'b1;
                    st_q <= S_RAMP;
                    tmr_q <= 17'h00000;
                    motion_fwd_out <= 1'b1; // [R1]
                end else if (is_wr || is_loop) begin
                    last_mark_q <= 1'b0;
                    loop_q <= is_loop;
                    busy_out <= 1'b1;
                    filling_q <= 1'b1; // [R8]
                    st_q <= S_RAMP;
                    tmr_q <= 17'h00000;
                    motion_fwd_out <= ~is_loop; // [R9] [R19]
                    loopback_out <= is_loop; // [R19]
                end
            end
            case (st_q)
                S_IDLE: begin
                    if (pend_v_q) begin
                        pend_v_q <= 1'b0; // [R10]
                        sense_lo_q[15:8] <= sb0_now;
                    end
                end
                S_RAMP: begin
                    tmr_q <= tmr_q + 17'h00001;
                    if (tmr_q >= RAMP_CYC[16:0] - 17'h00001 &&
                            (spd_ok_s || loop_q)) begin // [R9]
                        erase_out <= ~loop_q;
                        write_en_out <= 1'b1;
                        st_q <= last_mark_q ? S_MARK : S_WRITE;
                    end
                end
                S_MARK: begin
                    mark_out <= 1'b1; // [R1]
                    tmr_q <= 17'h00000;
                    st_q <= S_VERIFY;
                end
                S_WRITE: begin
                    drain_q <= fifo_out_valid;
                    if (drain_q && fifo_out_valid) begin
                        tape_data_out <= fifo_out_data; // [R5]
                        tape_data_valid_out <= 1'b1;
                        crc_q <= crc_q ^ fifo_out_data;
                    end
                    if (!filling_q && !fifo_out_valid && !drain_q) begin
                        st_q <= S_VERIFY; // [R6]
                    end
                end
                S_VERIFY: begin
                    mark_out <= 1'b0;
                    write_en_out <= 1'b0;
                    erase_out <= 1'b0;
                    if (rchk_s && !loop_q) begin // [R2] [R6]
                        err_cnt_q <= err_cnt_q + 8'h01; // [R13]
                        if (retry_q == `TFX_RETRY_FIRST - 4'h1) begin
                            if (first_blk_q ||
                                    rounds_q == `TFX_RETRY_LATER - 4'h1) begin
                                status2_out[`TFX_ST2_DCHK] <= 1'b1; // [R13]
                                status2_out[`TFX_FIFO_AW:0] <= fifo_cnt;
                                st_q <= S_DRAIN;
                            end else begin
                                rounds_q <= rounds_q + 4'h1; // [R12]
                                retry_q <= 4'h0;
                                st_q <= S_REPOS;
                            end
                        end else begin
                            retry_q <= retry_q + 4'h1; // [R11] [R12]
                            st_q <= S_REPOS;
                        end
                        motion_fwd_out <= 1'b0;
                        motion_rev_out <= 1'b1;
                    end else begin
                        st_q <= S_DRAIN;
                    end
                end
                S_REPOS: begin
                    // back to load point or one block, then rewrite
                    if (!first_blk_q || bot_s) begin // [R11] [R12]
                        motion_rev_out <= 1'b0;
                        motion_fwd_out <= 1'b1;
                        tmr_q <= 17'h00000;
                        st_q <= S_RAMP;
                    end
                end
                S_SDS: begin
                    if (ds_left_q != 4'h0) begin // [R15]
                        detail_data_out <= detail_word(ds_ptr_q,
                            {8'h00, err_cnt_q}, detail3_q, crc_q);
                        detail_valid_out <= 1'b1;
                        ds_ptr_q <= ds_ptr_q + 3'h1;
                        ds_left_q <= ds_left_q - 4'h1;
                        if (ds_ptr_q == 3'h7) begin
                            ds_left_q <= 4'h0;
                        end
                    end else begin
                        busy_out <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                S_DRAIN: begin
                    motion_fwd_out <= 1'b0; // [R2] [R6] stop in gap
                    motion_rev_out <= 1'b0;
                    loopback_out <= 1'b0;
                    first_blk_q <= 1'b0;
                    retry_q <= 4'h0;
                    rounds_q <= 4'h0;
                    mark_pend_q <= 1'b0;
                    detail3_q[15:8] <= sb0_now; // [R20]
                    if (!filling_q) begin
                        busy_out <= 1'b0; // [R3]
                    end
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: bench/tfx_task_executor_sva.sv
// Purpose: port assertions for the tape task executor
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module after the checker
`timescale 1ns/1ps
`default_nettype none
module tfx_task_executor_sva (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // watched ports
    input wire task_valid_in,
    input wire [15:0] task_code_in,
    input wire task_nak_out,
    input wire busy_out,
    input wire transfer_request_strobe_out,
    input wire [7:0] rate_div_in,
    input wire [15:0] status1_out,
    input wire motion_fwd_out,
    input wire motion_rev_out,
    input wire write_en_out,
    input wire mark_out,
    input wire loopback_out,
    input wire detail_valid_out,
    input wire tape_data_valid_out
);
    // ========================================
    // assertions
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_nop_nak_busy: assert property (task_valid_in && busy_out &&
        task_code_in == 16'h0000 |-> task_nak_out) else $error("nop not refused");
    a_nak_when_busy: assert property (task_nak_out |->
        busy_out && task_valid_in) else $error("refusal while idle");
    a_protect_no_motion: assert property ($rose(status1_out[11]) |->
        !motion_fwd_out && !write_en_out) else $error("protected moved");
    a_loop_no_motion: assert property (loopback_out |->
        !motion_fwd_out && !motion_rev_out) else $error("loop moved tape");
    a_mark_no_data: assert property (mark_out |->
        !tape_data_valid_out) else $error("data in mark");
    a_data_at_speed: assert property (tape_data_valid_out |->
        (motion_fwd_out && write_en_out) || loopback_out) else $error("data idle");
    a_strobe_single: assert property (transfer_request_strobe_out &&
        rate_div_in != 8'h00 |=> !transfer_request_strobe_out)
        else $error("strobe too long");
    a_detail_busy: assert property (task_valid_in && !busy_out &&
        task_code_in == 16'h0003 |=> busy_out) else $error("send not busy");
    // scenarios reached
    c_nak: cover property (task_nak_out);
    c_detail: cover property (detail_valid_out);
    c_tape_data: cover property (tape_data_valid_out);
endmodule
bind tfx_task_executor tfx_task_executor_sva tfx_task_executor_sva_i (.*);
`default_nettype wire

// file: bench/tfx_transport_model.sv
// Purpose: behavioural tape transport facing the executor
// Assumes: reaches speed after a short spin, never rewinds
// Notes: read check reported only while the write head is on
`timescale 1ns/1ps
`default_nettype none
module tfx_transport_model #(
    parameter logic [15:0] SPIN_CYC = 16'h0064
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // from executor and bench
    input wire logic motion_fwd_in,
    input wire logic motion_rev_in,
    input wire logic write_en_in,
    input wire logic protect_in,
    input wire logic err_in,
    input wire logic [2:0] speed_in,
    // transport pins
    output logic end_of_tape_flag_out,
    output logic load_point_flag_out,
    output logic reel_protect_flag_out,
    output logic rewinding_out,
    output logic online_out,
    output logic read_check_out,
    output logic up_to_speed_out,
    output logic [2:0] speed_code_out
);
    // ========================================
    // spin-up and position
    logic [15:0] spin_q;
    logic moved_q;
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            spin_q <= 16'h0000;
            moved_q <= 1'b0;
        end else begin
            if (!(motion_fwd_in || motion_rev_in))
                spin_q <= 16'h0000;
            else if (spin_q != SPIN_CYC)
                spin_q <= spin_q + 16'h0001;
            if (motion_fwd_in)
                moved_q <= 1'b1;
        end
    end
    assign up_to_speed_out = (spin_q == SPIN_CYC);
    assign read_check_out = err_in && write_en_in;
    assign load_point_flag_out = !moved_q;
    assign end_of_tape_flag_out = 1'b0;
    assign reel_protect_flag_out = protect_in;
    assign rewinding_out = 1'b0;
    assign online_out = 1'b1;
    assign speed_code_out = speed_in;
endmodule
`default_nettype wire

// file: bench/tfx_task_executor_bench.sv
// Purpose: self-checking bench for the tape task executor
// Assumes: inputs driven on the falling edge
// Notes: one buffered write spans the full spin-up ramp
`timescale 1ns/1ps
`default_nettype none
module tfx_task_executor_bench;
    logic clk, rst_n, tvalid, nak, busy, buffered, wvalid = 1'b0, stop;
    logic strobe, dvalid, fwd, rev, erase, wen, mark, loopb, tvld, feed;
    logic eot, bot, prot, rew, onl, rchk, uts, protect;
    logic [15:0] tcode, wdata = 16'h0000, rdata, st1, st2, ddata, tdata;
    logic [15:0] r1, r2;
    logic [7:0] raddr, rate;
    logic [3:0] range;
    logic [2:0] spd, speed;
    logic [3:0] rng [4] = '{4'h1, 4'h3, 4'h8, 4'hc};
    logic [31:0] exp_n [4] = '{32'h1, 32'h3, 32'h8, 32'h8};
    logic [15:0] tape_q [$];
    int bad_count = 0, cmp_count = 0, n_det = 0, n_strobe = 0, n_fed = 0;
    logic mark_seen = 1'b0;
    tfx_task_executor tfx_task_executor_i (.sys_clk_in(clk), .rst_n_in(rst_n),
        .task_valid_in(tvalid), .task_code_in(tcode), .task_nak_out(nak),
        .busy_out(busy), .buffered_mode_in(buffered),
        .config_word_in(16'h0000), .wr_data_valid_in(wvalid),
        .wr_data_in(wdata), .adapter_stop_in(stop),
        .transfer_request_strobe_out(strobe), .rate_div_in(rate),
        .reg_addr_in(raddr), .reg_data_out(rdata), .status1_out(st1),
        .status2_out(st2), .detail_data_out(ddata), .detail_valid_out(dvalid),
        .detail_range_in(range), .end_of_tape_flag_in(eot),
        .load_point_flag_in(bot), .reel_protect_flag_in(prot),
        .rewinding_in(rew), .online_in(onl), .read_check_in(rchk),
        .up_to_speed_in(uts), .speed_code_in(spd), .motion_fwd_out(fwd),
        .motion_rev_out(rev), .erase_out(erase), .write_en_out(wen),
        .mark_out(mark), .loopback_out(loopb), .tape_data_out(tdata),
        .tape_data_valid_out(tvld));
    tfx_transport_model tfx_transport_model_i (.sys_clk_in(clk),
        .rst_n_in(rst_n), .motion_fwd_in(fwd), .motion_rev_in(rev),
        .write_en_in(wen), .protect_in(protect), .err_in(1'b0),
        .speed_in(speed), .end_of_tape_flag_out(eot),
        .load_point_flag_out(bot), .reel_protect_flag_out(prot),
        .rewinding_out(rew), .online_out(onl), .read_check_out(rchk),
        .up_to_speed_out(uts), .speed_code_out(spd));
    // ========================================
    // clock, watchdog and monitor
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #(90000 * 5);
        bad_count++;
        print_verdict();
    end
    // one word per request strobe
    always @(negedge clk) begin
        wvalid = 1'b0;
        if (feed && strobe === 1'b1 && n_fed < 4) begin
            wvalid = 1'b1;
            wdata = 16'ha5a0 + 16'(n_fed);
            n_fed++;
        end
        if (strobe === 1'b1) n_strobe++;
        if (tvld === 1'b1) tape_q.push_back(tdata);
        if (dvalid === 1'b1) n_det++;
        if (mark === 1'b1) mark_seen = 1'b1;
    end
    // ========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic issue(input logic [15:0] code);
        int n = 0;
        while (busy !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        tcode = code;
        tvalid = 1'b1;
        @(negedge clk);
        tvalid = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        raddr = a;
        #1 d = rdata;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ========================================
    // scenarios
    initial begin
        rst_n = 1'b0; tvalid = 1'b0; tcode = 16'h0000; buffered = 1'b0;
        stop = 1'b0; rate = 8'h03; raddr = 8'h00; range = 4'h1;
        protect = 1'b0; speed = 3'h4; feed = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(8'h1e, r1);
        chk(r1, 16'h8400);
        speed = 3'h0;
        repeat (4) @(negedge clk);
        rd(8'h1e, r2);
        chk(r2, r1);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(8'h1e, r2);
        chk(r2, 16'h8000);
        for (int i = 0; i < 4; i++) begin
            range = rng[i];
            n_det = 0;
            issue(16'h0003);
            tcode = 16'h0000;
            tvalid = (i == 3);
            #1 if (i == 3) chk(32'(nak), 32'h1);
            @(negedge clk);
            tvalid = 1'b0;
            repeat (40) @(negedge clk);
            chk(32'(n_det), exp_n[i]);
        end
        protect = 1'b1;
        n_strobe = 0;
        repeat (4) @(negedge clk);
        issue(16'h0002);
        repeat (50) @(negedge clk);
        chk(32'(st1[11]), 32'h1);
        chk(32'(n_strobe) + 32'(fwd), 32'h0);
        protect = 1'b0;
        repeat (4) @(negedge clk);
        issue(16'h0001);
        issue(16'h0000);
        chk(32'(mark_seen), 32'h1);
        chk(32'(fwd), 32'h0);
        buffered = 1'b1;
        feed = 1'b1;
        n_strobe = 0;
        tape_q.delete();
        issue(16'h0002);
        repeat (200) @(negedge clk);
        chk(32'(n_strobe), 32'h4);
        chk(32'(fwd), 32'h1);
        stop = 1'b1;
        repeat (20) @(negedge clk);
        chk(32'(busy), 32'h0);
        stop = 1'b0;
        n_det = 0;
        issue(16'h0003);
        for (int n = 0; n < 30000 && tape_q.size() < 4; n++) @(negedge clk);
        chk(32'(n_det), 32'h0);
        for (int i = 0; i < 4; i++) chk(tape_q[i], 16'ha5a0 + 16'(i));
        repeat (100) @(negedge clk);
        chk(32'(n_det), 32'h8);
        print_verdict();
    end
endmodule
`default_nettype wire
